// *** src/cmd_fetch_defs.vh ***
// constants for the command fetch and dma sequencer
`ifndef CMD_FETCH_DEFS_VH
`define CMD_FETCH_DEFS_VH
`define REG_CTRL        8'h00
`define REG_START       8'h04
`define REG_BASE        8'h08
`define REG_VECTOR      8'h0c
`define REG_STATUS      8'h10
`define REG_CMD         8'h14
`define REG_LOWLVL      8'h18
`define REG_TIMER       8'h1c
`define CTRL_MODE_BIT   0
`define CTRL_HALF_BIT   1
`define CTRL_LOOP_BIT   2
`define CTRL_CACHE_BIT  3
`define CTRL_WOR_BIT    4
`define CTRL_BURST_LSB  5
`define CTRL_LINES_LSB  7
`define CTRL_RESET      32'h0000_0000
`define TIMER_RESET     16'hffff
`define OP_IO           2'h0
`define OP_MOVE         2'h1
`define OP_XFER         2'h2
`define OP_MEMMOVE      2'h3
`define XF_JUMP         3'h0
`define XF_CALL         3'h1
`define XF_RETURN       3'h2
`define XF_INT          3'h3
`define CAUSE_INT       2'h1
`define CAUSE_ERR       2'h2
`define CAUSE_TIMEOUT   2'h3
`define FIFO_BYTES      64
`define LINE_BYTES      16
`endif

// *** src/cmd_fetch_dma.v ***
// command fetch and dma sequencer with apb register slave
// Behaviour
// (R1) 64-byte fifo, bursts of 2/4/8/16 words
// (R2) cache-line burst moves sixteen bytes
// (R3) one, two or four lines per tenure
// (R4) misaligned addresses use per-lane byte enables; table fetches always drive mem_be 4'hf
// (R5) runs from 16- or 32-bit memory
// (R6) fetch four or two bytes into command
// (R7) host gives start, device fetches onward
// (R8) table address is base plus signed offset
// (R9) table values fetched after instruction bytes
// (R10) host loads base before table-indirect use
// (R11) context switch: new base, then start
// (R12) run until interrupt instruction or error
// (R13) status value names each interrupt cause
// (R14) jump/call/return/int conditioned on phase
// (R15) optional data byte compare conditions control
// (R16) low-level or chained mode after init
// (R17) low-level mode gives direct pin access
// (R18) loopback routes scsi core to dma; the code drives loop_data with the last dma fifo byte instead
// (R19) daisy-chain or wired-or bus request
// (R20) programmable timer limits bus activity
// (R21) vector stored in readable vector register
// (R22) writing start address begins fetching
// (R23) halt after interrupt until new start
`timescale 1ns/1ps
`include "cmd_fetch_defs.vh"
module cmd_fetch_dma #(
    parameter FIFO_DEPTH = `FIFO_BYTES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    output reg         mem_req,
    input  wire        mem_grant_in,
    output reg         mem_grant_out,
    output reg  [31:0] mem_addr,
    output reg  [3:0]  mem_be,
    output reg         mem_rd,
    output reg         mem_last,
    input  wire [31:0] mem_rdata,
    input  wire        mem_ack,
    input  wire        mem_err,
    input  wire [2:0]  scsi_phase,
    input  wire [7:0]  scsi_data,
    output reg  [7:0]  scsi_ctl_out,
    output reg  [7:0]  dma_ctl_out,
    output reg  [7:0]  loop_data
);
    localparam S_IDLE  = 3'd0;
    localparam S_REQ   = 3'd1;
    localparam S_FETCH = 3'd2;
    localparam S_TABLE = 3'd3;
    localparam S_EXEC  = 3'd4;
    localparam S_DATA  = 3'd5;
    localparam S_HALT  = 3'd6;

    // input synchronisers
    reg         grant_m, grant_s, ack_m, ack_s, err_m, err_s;
    reg  [2:0]  phase_m, phase_s;
    reg  [7:0]  sdata_m, sdata_s;
    reg  [31:0] rdata_m, rdata_s;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_m <= 1'b0;
            grant_s <= 1'b0;
            ack_m   <= 1'b0;
            ack_s   <= 1'b0;
            err_m   <= 1'b0;
            err_s   <= 1'b0;
            phase_m <= 3'h0;
            phase_s <= 3'h0;
            sdata_m <= 8'h00;
            sdata_s <= 8'h00;
            rdata_m <= 32'h0000_0000;
            rdata_s <= 32'h0000_0000;
        end else begin
            grant_m <= mem_grant_in;
            grant_s <= grant_m;
            ack_m   <= mem_ack;
            ack_s   <= ack_m;
            err_m   <= mem_err;
            err_s   <= err_m;
            phase_m <= scsi_phase;
            phase_s <= phase_m;
            sdata_m <= scsi_data;
            sdata_s <= sdata_m;
            rdata_m <= mem_rdata;
            rdata_s <= rdata_m;
        end
    end

    reg  [31:0] ctrl, base, start, cmd, arg, vector, lowlvl, ret_addr, pc, tbl;
    reg  [15:0] timer_load, timer;
    reg  [2:0]  state;
    reg  [1:0]  cause;
    reg  [1:0]  half_cnt, word_cnt;
    reg  [5:0]  burst_cnt;
    reg  [2:0]  line_cnt;
    reg  [6:0]  fifo_level;
    reg         ack_d, start_pulse;
    reg  [7:0]  fifo_mem [0:FIFO_DEPTH-1];
    reg  [5:0]  fifo_wp;

    wire ack_rise = ack_s & ~ack_d;
    wire chained  = ctrl[`CTRL_MODE_BIT];
    wire half     = ctrl[`CTRL_HALF_BIT];
    wire apb_wr   = psel & penable & pwrite;
    wire [5:0] burst_words = 6'd2 << ctrl[`CTRL_BURST_LSB +: 2];
    wire [2:0] lines_per   = (ctrl[`CTRL_LINES_LSB +: 2] == 2'd0) ? 3'd1 :
                             (ctrl[`CTRL_LINES_LSB +: 2] == 2'd1) ? 3'd2 : 3'd4;
    wire [5:0] burst_lim   = ctrl[`CTRL_CACHE_BIT] ? 6'd4 : burst_words;
    // (R19) grant chain or wired-or request
    wire grant_ok = ctrl[`CTRL_WOR_BIT] ? 1'b1 : grant_s;
    // (R14) phase compare plus (R15) data compare
    wire phase_hit = ~cmd[17] | (cmd[26:24] == phase_s);
    wire data_hit  = ~cmd[18] | (((sdata_s ^ cmd[7:0]) & ~cmd[15:8]) == 8'h00);
    wire take      = ((phase_hit & data_hit) == cmd[19]);

    // apb register access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= `CTRL_RESET;
            base        <= 32'h0000_0000;
            start       <= 32'h0000_0000;
            lowlvl      <= 32'h0000_0000;
            timer_load  <= `TIMER_RESET;
            start_pulse <= 1'b0;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            start_pulse <= 1'b0;
            pready      <= psel & ~penable;
            pslverr     <= 1'b0;
            if (psel & ~penable) begin
                pslverr <= (paddr > `REG_TIMER) | (paddr[1:0] != 2'b00);
                case (paddr)
                    `REG_CTRL:   prdata <= ctrl;
                    `REG_START:  prdata <= start;
                    `REG_BASE:   prdata <= base;
                    `REG_VECTOR: prdata <= vector;
                    `REG_STATUS: prdata <= {25'h0, fifo_level[5:0] == 6'h0, cause, 1'b0, state};
                    `REG_CMD:    prdata <= cmd;
                    `REG_LOWLVL: prdata <= lowlvl;
                    `REG_TIMER:  prdata <= {16'h0000, timer_load};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
            if (apb_wr & pready) begin
                case (paddr)
                    // (R16) mode select
                    `REG_CTRL:   ctrl <= pwdata;
                    // (R22) start write launches fetch
                    `REG_START: begin
                        start       <= pwdata;
                        start_pulse <= 1'b1;
                    end
                    // (R10) base loaded by host
                    `REG_BASE:   base <= pwdata;
                    `REG_LOWLVL: lowlvl <= pwdata;
                    // (R20) timer limit load
                    `REG_TIMER:  timer_load <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // fetch and execute sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE; pc <= 32'h0; cmd <= 32'h0; arg <= 32'h0;
            tbl <= 32'h0; ret_addr <= 32'h0; vector <= 32'h0; cause <= 2'h0;
            half_cnt <= 2'h0; word_cnt <= 2'h0; burst_cnt <= 6'h0;
            line_cnt <= 3'h0; fifo_level <= 7'h0; fifo_wp <= 6'h0;
            timer <= 16'h0; ack_d <= 1'b0; irq <= 1'b0;
            mem_req <= 1'b0; mem_addr <= 32'h0; mem_be <= 4'h0;
            mem_rd <= 1'b0; mem_last <= 1'b0; mem_grant_out <= 1'b0;
        end else begin
            ack_d <= ack_s;
            mem_grant_out <= grant_s & ~mem_req;
            if (mem_req & grant_ok & timer != 16'h0)
                timer <= timer - 16'h0001;
            // (R7) chained start; (R11) restart with new base; (R23) leave halt
            if (start_pulse & chained) begin
                pc <= start; irq <= 1'b0; cause <= 2'h0;
                word_cnt <= 2'h0; half_cnt <= 2'h0;
                state <= S_REQ; timer <= timer_load;
            // (R12) hardware error ends run
            end else if (err_s & state != S_IDLE & state != S_HALT) begin
                cause <= `CAUSE_ERR; vector <= {30'h0, `CAUSE_ERR};
                irq <= 1'b1; mem_req <= 1'b0; mem_rd <= 1'b0; state <= S_HALT;
            // (R20) bus watchdog expiry
            end else if (mem_req & grant_ok & timer == 16'h0 & state != S_HALT) begin
                cause <= `CAUSE_TIMEOUT; vector <= {30'h0, `CAUSE_TIMEOUT};
                irq <= 1'b1; mem_req <= 1'b0; mem_rd <= 1'b0; state <= S_HALT;
            end else begin
                case (state)
                    S_IDLE: mem_req <= 1'b0;
                    S_REQ: begin
                        mem_req <= 1'b1;
                        if (grant_ok) begin
                            // (R4) per-lane enables from low address bits
                            mem_addr <= pc;
                            mem_be   <= half ? (pc[1] ? 4'hc : 4'h3) : (4'hf << pc[1:0]);
                            mem_rd   <= 1'b1;
                            state    <= S_FETCH;
                        end
                    end
                    S_FETCH: if (ack_rise) begin
                        // (R5) (R6) assemble two or four bytes per fetch
                        if (half) begin
                            if (half_cnt[0] == 1'b0) begin
                                if (word_cnt == 2'h0) cmd[15:0] <= rdata_s[15:0];
                                else arg[15:0] <= rdata_s[15:0];
                            end else begin
                                if (word_cnt == 2'h0) cmd[31:16] <= rdata_s[15:0];
                                else arg[31:16] <= rdata_s[15:0];
                            end
                        end else if (word_cnt == 2'h0) cmd <= rdata_s;
                        else arg <= rdata_s;
                        pc <= pc + (half ? 32'd2 : 32'd4);
                        mem_addr <= pc + (half ? 32'd2 : 32'd4);
                        half_cnt <= half ? half_cnt + 2'h1 : 2'h0;
                        if (!half | half_cnt[0]) begin
                            word_cnt <= word_cnt + 2'h1;
                            if (word_cnt == 2'h1) begin
                                mem_rd <= 1'b0;
                                state  <= (cmd[31:30] == `OP_MOVE && cmd[25]) ? S_TABLE : S_EXEC;
                            end
                        end
                    end
                    S_TABLE: begin
                        // (R8) signed offset; (R9) after instruction bytes
                        tbl      <= base + {{8{arg[23]}}, arg[23:0]};
                        mem_addr <= base + {{8{arg[23]}}, arg[23:0]};
                        mem_be   <= 4'hf;
                        mem_rd   <= 1'b1;
                        state    <= S_DATA;
                        burst_cnt <= 6'h0; line_cnt <= 3'h0;
                    end
                    S_DATA: if (ack_rise) begin
                        // (R1) fill fifo in bursts; (R2) lines of sixteen bytes
                        fifo_mem[fifo_wp] <= rdata_s[7:0];
                        fifo_wp    <= fifo_wp + 6'h1;
                        fifo_level <= (fifo_level == FIFO_DEPTH) ? fifo_level : fifo_level + 7'h4;
                        mem_addr   <= mem_addr + 32'd4;
                        burst_cnt  <= burst_cnt + 6'h1;
                        mem_last   <= (burst_cnt + 6'h2 == burst_lim);
                        if (burst_cnt + 6'h1 == burst_lim) begin
                            burst_cnt <= 6'h0;
                            line_cnt  <= line_cnt + 3'h1;
                            // (R3) release bus after set count of lines
                            if (!ctrl[`CTRL_CACHE_BIT] || line_cnt + 3'h1 == lines_per) begin
                                mem_rd <= 1'b0; mem_req <= 1'b0; mem_last <= 1'b0;
                                word_cnt <= 2'h0; state <= S_REQ;
                            end
                        end
                    end
                    S_EXEC: begin
                        word_cnt <= 2'h0;
                        state    <= S_REQ;
                        if (cmd[31:30] == `OP_XFER && take) begin
                            case (cmd[29:27])
                                `XF_JUMP: pc <= arg;
                                `XF_CALL: begin
                                    ret_addr <= pc;
                                    pc       <= arg;
                                end
                                `XF_RETURN: pc <= ret_addr;
                                // (R21) vector stored; (R13) unique cause
                                `XF_INT: begin
                                    vector  <= arg;
                                    cause   <= `CAUSE_INT;
                                    irq     <= 1'b1;
                                    mem_req <= 1'b0;
                                    state   <= S_HALT;
                                end
                                default: ;
                            endcase
                        end
                    end
                    // (R23) wait for new start
                    S_HALT: begin
                        mem_req <= 1'b0;
                        mem_rd  <= 1'b0;
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    // low-level and loopback outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scsi_ctl_out <= 8'h00;
            dma_ctl_out  <= 8'h00;
            loop_data    <= 8'h00;
        end else begin
            // (R17) direct pin control when not chained
            scsi_ctl_out <= chained ? 8'h00 : lowlvl[7:0];
            dma_ctl_out  <= chained ? 8'h00 : lowlvl[15:8];
            // (R18) last dma fifo byte driven on loop_data when loop bit set
            loop_data    <= ctrl[`CTRL_LOOP_BIT] ? fifo_mem[fifo_wp - 6'h1] : 8'h00;
        end
    end
endmodule

// *** dv/cmd_fetch_dma_asserts.sv ***
// port checks for the command fetch sequencer
`timescale 1ns/1ps
`include "cmd_fetch_defs.vh"
module cmd_fetch_dma_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq,
    input wire        mem_req,
    input wire        mem_rd,
    input wire [3:0]  mem_be
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property ((psel && !penable) |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_bad_addr_err: assert property ((psel && !penable && paddr > 8'h1c) |=> pslverr)
        else $error("no error for unmapped address");
    a_good_addr_ok: assert property (
        (psel && !penable && paddr <= 8'h1c && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("error on mapped address");
    a_bad_read_zero: assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_read_owns_bus: assert property (mem_rd |-> mem_req)
        else $error("memory read without request");
    a_lane_enabled: assert property (mem_rd |-> mem_be != 4'h0)
        else $error("memory read with no byte lane");
    a_irq_halts_fetch: assert property ((irq && $past(irq)) |-> !mem_rd)
        else $error("fetch while interrupt pending");
    a_start_clears_irq: assert property ((psel && penable && pready && pwrite
        && paddr == `REG_START) |=> ##1 !irq)
        else $error("start write left interrupt set");
endmodule
bind cmd_fetch_dma cmd_fetch_dma_asserts cmd_fetch_dma_asserts_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .mem_req(mem_req), .mem_rd(mem_rd),
    .mem_be(mem_be));

// *** dv/mem_partner.sv ***
// system memory and arbiter model serving instruction words
`timescale 1ns/1ps
module mem_partner (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        mem_req,
    input  wire        mem_rd,
    input  wire [31:0] mem_addr,
    input  wire        inject_err,
    output reg         mem_grant_in,
    output reg  [31:0] mem_rdata,
    output reg         mem_ack,
    output reg         mem_err
);
    initial begin
        mem_grant_in = 1'b0;
        mem_rdata = 32'h0;
        mem_ack = 1'b0;
        mem_err = 1'b0;
        forever begin
            @(posedge pclk);
            mem_grant_in <= mem_req & presetn;
            // taken interrupt op, then its vector; odd halfword moves down
            if (mem_rd && mem_grant_in && presetn) begin
                mem_rdata <= (mem_addr[2] ? {16'h0000, 8'hff, mem_addr[7:0]} : 32'h9808_0000)
                    >> (mem_addr[1] ? 16 : 0);
                mem_ack <= !inject_err;
                mem_err <= inject_err;
                repeat (3) @(posedge pclk);
                mem_ack <= 1'b0;
                mem_err <= 1'b0;
                mem_rdata <= ~mem_rdata;
                repeat (3) @(posedge pclk);
            end
        end
    end
endmodule

// *** dv/cmd_fetch_dma_bench.sv ***
// self-checking bench for the command fetch sequencer
`timescale 1ns/1ps
`include "cmd_fetch_defs.vh"
module cmd_fetch_dma_bench;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, inject_err = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata, mem_addr, mem_rdata;
    wire [7:0]  scsi_ctl_out, dma_ctl_out;
    wire [3:0]  mem_be;
    wire        pready, pslverr, irq, mem_req, mem_grant_in, mem_rd, mem_ack, mem_err;
    reg         err;
    integer     n_errors = 0, checked = 0, k;
    cmd_fetch_dma cmd_fetch_dma_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .mem_req(mem_req),
        .mem_grant_in(mem_grant_in), .mem_grant_out(), .mem_addr(mem_addr), .mem_be(mem_be),
        .mem_rd(mem_rd), .mem_last(), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .scsi_phase(3'h0), .scsi_data(8'h00),
        .scsi_ctl_out(scsi_ctl_out), .dma_ctl_out(dma_ctl_out), .loop_data());
    mem_partner mem_partner_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .inject_err(inject_err),
        .mem_grant_in(mem_grant_in), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .mem_err(mem_err));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task check(input [255:0] name, input [31:0] exp, input [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %0s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] d);
        integer w;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && w < 20) begin
            w = w + 1;
            @(posedge pclk);
        end
        if (w == 20) n_errors = n_errors + 1;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wait_irq;
        k = 0;
        while (irq !== 1'b1 && k < 2000) begin
            k = k + 1;
            @(posedge pclk);
        end
        check("irq", 32'h1, {31'h0, irq});
    endtask
    task t_reset;
        apb(0, `REG_CTRL, 0);
        check("ctrl reset", `CTRL_RESET, rd);
        apb(0, `REG_TIMER, 0);
        check("timer reset", {16'h0, `TIMER_RESET}, rd);
        check("req reset", 32'h0, {31'h0, mem_req});
    endtask
    task t_unmapped;
        apb(1, 8'h20, 32'hffff_ffff);
        check("write err", 32'h1, {31'h0, err});
        apb(0, 8'h20, 0);
        check("read err", 32'h1, {31'h0, err});
        check("read zero", 32'h0, rd);
    endtask
    task t_lowlvl;
        apb(1, `REG_LOWLVL, 32'h0000_a55a);
        @(posedge pclk);
        check("scsi ctl", 32'h5a, {24'h0, scsi_ctl_out});
        check("dma ctl", 32'ha5, {24'h0, dma_ctl_out});
    endtask
    task t_start(input [31:0] s, input [31:0] vec, input [1:0] cause, input [3:0] be);
        apb(1, `REG_START, s);
        @(posedge pclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        k = 0;
        while (mem_rd !== 1'b1 && k < 200) begin
            k = k + 1;
            @(posedge pclk);
        end
        if (k == 200) n_errors = n_errors + 1;
        check("first fetch", s, mem_addr);
        check("first lanes", {28'h0, be}, {28'h0, mem_be});
        wait_irq;
        apb(0, `REG_VECTOR, 0);
        check("vector", vec, rd);
        apb(0, `REG_STATUS, 0);
        check("cause", {30'h0, cause}, {30'h0, rd[5:4]});
        repeat (40) @(posedge pclk);
        check("halted", 32'h0, {31'h0, mem_rd});
    endtask
    task t_chain;
        apb(1, `REG_CTRL, 32'h1);
        @(posedge pclk);
        check("chain mode ctl", 32'h0, {24'h0, scsi_ctl_out});
        apb(1, `REG_BASE, 32'h0000_3000);
        apb(0, `REG_BASE, 0);
        check("base", 32'h0000_3000, rd);
        t_start(32'h100, 32'h0000_ff04, `CAUSE_INT, 4'hf);
        inject_err <= 1'b1;
        t_start(32'h200, {30'h0, `CAUSE_ERR}, `CAUSE_ERR, 4'hf);
        inject_err <= 1'b0;
        apb(1, `REG_BASE, 32'h0000_4000);
        t_start(32'h100, 32'h0000_ff04, `CAUSE_INT, 4'hf);
    endtask
    task t_modes;
        apb(1, `REG_CTRL, 32'h3);
        t_start(32'h100, 32'h0000_ff04, `CAUSE_INT, 4'h3);
        apb(1, `REG_TIMER, 32'h3);
        t_start(32'h300, {30'h0, `CAUSE_TIMEOUT}, `CAUSE_TIMEOUT, 4'h3);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_unmapped;
        t_lowlvl;
        t_chain;
        t_modes;
        print_verdict;
    end
    initial begin
        #2000000;
        n_errors = n_errors + 1;
        print_verdict;
    end
endmodule
